// ---- src/serial_port_async_sync.v ----
// serial port: apb registers, async/clock-sync transmitter and receiver, status flags
// Function
// - mode bit 7: 0 asynchronous framing, 1 clock synchronous operation
// - character length bit: in async mode 0 gives 8 data bits, 1 gives 7; clock synchronous mode always uses 8
// - parity enable bit 5 adds a parity bit when 1, none when 0; clock synchronous mode never adds one
// - stop length bit: in async mode transmitter sends one stop bit at 0, two at 1; clock synchronous mode sends none
// - receiver checks first stop bit only; low after it starts next frame
// - 8-bit writable divisor with prescale sets the bit rate
// - control bit 7 gates the transmit-empty request
// - receive interrupt enable gates both receive-full and receive-error requests
// - transmit enable bit 5 and receive enable bit 4 allow each direction
// - control bit 2 gates the transmit-complete request
// - clock source bits 00 take timing from the on-chip generator
// - transmit-empty flag set while transmit disabled and on each shift load
// - transmit-empty cleared by 0 write after reading 1, or dma load while the transmit-empty request is raised
// - receive-full flag set when an error-free byte reaches the holding register
// - receive-full cleared by 0 write after reading 1, or dma read while the receive-full request is raised
// - clearing receive enable leaves receive-full unchanged
// - a byte finishing while receive-full is 1 sets overrun, byte dropped
// - overrun cleared only by 0 write after reading it as 1
// - framing error flag bit 4 set on bad frame, read-1 write-0 clears
// - parity error flag bit 3 set on mismatch, read-1 write-0 clears
// - writing 1 to a clear-only flag does nothing
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "serial_port_consts.vh"
module serial_port_async_sync (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire dma_tx_we,
  input wire [7:0] dma_tx_data,
  input wire dma_rx_ack,
  output reg [7:0] rx_data,
  input wire rxd,
  output reg txd,
  output reg sck,
  output reg tx_empty_irq,
  output reg rx_full_irq,
  output reg rx_err_irq,
  output reg tx_done_irq
);
  localparam T_IDLE = 3'd0;
  localparam T_START = 3'd1;
  localparam T_DATA = 3'd2;
  localparam T_PAR = 3'd3;
  localparam T_STOP = 3'd4;
  localparam R_IDLE = 3'd0;
  localparam R_START = 3'd1;
  localparam R_DATA = 3'd2;
  localparam R_PAR = 3'd3;
  localparam R_STOP = 3'd4;

  reg [7:0] frame_mode;
  reg [7:0] bit_rate_divisor;
  reg [7:0] serial_control;
  reg [7:0] tx_hold_reg;
  reg [4:0] flags;
  reg [4:0] armed;
  reg tx_end;

  wire sync_mode = frame_mode[`MODE_SYNC_BIT];
  wire char_len_sel = frame_mode[`MODE_CHAR_LEN_BIT];
  wire parity_enable = frame_mode[`MODE_PARITY_EN_BIT];
  wire parity_odd = frame_mode[`MODE_PARITY_ODD_BIT];
  wire stop_two = frame_mode[`MODE_STOP_LEN_BIT];
  wire [1:0] prescale = frame_mode[`MODE_PRESCALE_HI:`MODE_PRESCALE_LO];
  wire tx_irq_en = serial_control[`CTL_TX_IRQ_EN_BIT];
  wire rx_irq_en = serial_control[`CTL_RX_IRQ_EN_BIT];
  wire tx_enable = serial_control[`CTL_TX_EN_BIT];
  wire rx_enable = serial_control[`CTL_RX_EN_BIT];
  wire txdone_irq_en = serial_control[`CTL_TXDONE_IRQ_EN_BIT];
  wire [1:0] clk_src = serial_control[`CTL_CLK_SRC_HI:`CTL_CLK_SRC_LO];
  wire tx_hold_empty = flags[`FLAG_TX_EMPTY];
  wire rx_hold_full = flags[`FLAG_RX_FULL];

  // apb decode
  wire [7:0] reg_idx = paddr[9:2];
  // indexes are full 24-bit numbers; only the low byte travels on paddr
  wire [23:0] idx_full = {16'hFFFE, reg_idx};
  wire hit_mode = idx_full == `IDX_FRAME_MODE;
  wire hit_div = idx_full == `IDX_BIT_RATE_DIVISOR;
  wire hit_ctl = idx_full == `IDX_SERIAL_CONTROL;
  wire hit_txh = idx_full == `IDX_TX_HOLD;
  wire hit_stat = idx_full == `IDX_SERIAL_STATUS;
  wire hit_rxh = idx_full == `IDX_RX_HOLD;
  wire mapped = hit_mode | hit_div | hit_ctl | hit_txh | hit_stat | hit_rxh;
  wire setup = psel & ~penable;
  wire done = psel & penable & pready;
  wire wr_lane = pwrite & pstrb[0] & done;
  wire wr_ok = wr_lane & mapped;
  wire rd_stat = done & ~pwrite & hit_stat;

  reg [7:0] rd_mux;
  always @* begin
    rd_mux = 8'h00;
    if (hit_mode) rd_mux = frame_mode;
    if (hit_div) rd_mux = bit_rate_divisor;
    if (hit_ctl) rd_mux = serial_control;
    if (hit_txh) rd_mux = tx_hold_reg;
    if (hit_stat) rd_mux = {flags, tx_end, 2'b00};
    if (hit_rxh) rd_mux = rx_data;
  end

  // one wait-free access phase: pready rises in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= ~mapped;
        prdata <= {24'h000000, rd_mux};
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_mode <= `RST_FRAME_MODE;
      bit_rate_divisor <= `RST_DIVISOR;
      serial_control <= `RST_CONTROL;
      tx_hold_reg <= 8'h00;
    end else begin
      if (wr_ok && hit_mode) frame_mode <= pwdata[7:0];
      if (wr_ok && hit_div) bit_rate_divisor <= pwdata[7:0];
      if (wr_ok && hit_ctl) serial_control <= pwdata[7:0];
      if (dma_tx_we) tx_hold_reg <= dma_tx_data;
      else if (wr_ok && hit_txh) tx_hold_reg <= pwdata[7:0];
    end
  end

  // bit clock
  wire os_tick;
  baud_tick_gen u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .run(clk_src == `CLK_SRC_INTERNAL),
    .prescale(prescale),
    .divisor(bit_rate_divisor),
    .tick(os_tick)
  );

  // receive pin synchroniser
  reg rxd_meta;
  reg rxd_s;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_meta <= 1'b1;
      rxd_s <= 1'b1;
    end else begin
      rxd_meta <= rxd;
      rxd_s <= rxd_meta;
    end
  end

  // transmitter
  reg [2:0] tx_state;
  reg [3:0] tx_os;
  reg [2:0] tx_idx;
  reg [7:0] tx_shift_reg;
  reg tx_par;
  reg tx_stop2nd;
  wire tx_bit_end = os_tick && tx_os == `OS_LAST;
  wire [2:0] tx_last = (char_len_sel && !sync_mode) ? 3'd6 : 3'd7;
  wire tx_load = tx_state == T_IDLE && tx_enable && !tx_hold_empty;
  wire [7:0] load_mask = char_len_sel ? 8'h7F : 8'hFF;
  reg tx_finish;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= T_IDLE;
      tx_os <= 4'h0;
      tx_idx <= 3'd0;
      tx_shift_reg <= 8'hFF;
      tx_par <= 1'b0;
      tx_stop2nd <= 1'b0;
      tx_finish <= 1'b0;
    end else begin
      tx_finish <= 1'b0;
      if (tx_state != T_IDLE && os_tick) tx_os <= tx_os + 4'h1;
      case (tx_state)
        T_IDLE: begin
          tx_os <= 4'h0;
          if (tx_load) begin
            tx_shift_reg <= tx_hold_reg;
            tx_par <= ^(tx_hold_reg & load_mask) ^ parity_odd;
            tx_idx <= 3'd0;
            tx_state <= sync_mode ? T_DATA : T_START;
          end
        end
        T_START: begin
          if (tx_bit_end) tx_state <= T_DATA;
        end
        T_DATA: begin
          if (tx_bit_end) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
            tx_idx <= tx_idx + 3'd1;
            if (tx_idx == tx_last) begin
              tx_stop2nd <= 1'b0;
              if (sync_mode) begin
                tx_state <= T_IDLE;
                tx_finish <= 1'b1;
              end else if (parity_enable) begin
                tx_state <= T_PAR;
              end else begin
                tx_state <= T_STOP;
              end
            end
          end
        end
        T_PAR: begin
          if (tx_bit_end) tx_state <= T_STOP;
        end
        T_STOP: begin
          if (tx_bit_end) begin
            if (stop_two && !tx_stop2nd) begin
              tx_stop2nd <= 1'b1;
            end else begin
              tx_state <= T_IDLE;
              tx_finish <= 1'b1;
            end
          end
        end
        default: tx_state <= T_IDLE;
      endcase
    end
  end

  // line and clock pins; sync clock is low in the first half of each bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd <= 1'b1;
      sck <= 1'b1;
    end else begin
      case (tx_state)
        T_START: txd <= 1'b0;
        T_DATA: txd <= tx_shift_reg[0];
        T_PAR: txd <= tx_par;
        default: txd <= 1'b1;
      endcase
      sck <= !(sync_mode && tx_state == T_DATA) || tx_os[3];
    end
  end

  // receiver
  reg [2:0] rx_state;
  reg [3:0] rx_os;
  reg [2:0] rx_idx;
  reg [7:0] rx_shift_reg;
  reg rx_par;
  reg rx_done;
  reg rx_frame_bad;
  reg rx_par_bad;
  reg [7:0] rx_word;
  wire rx_mid = os_tick && rx_os == `OS_LAST;
  wire [2:0] rx_last = (char_len_sel && !sync_mode) ? 3'd6 : 3'd7;
  // sync reception rides on the transmitter's clock, sampled at the rising edge
  wire sync_sample = sync_mode && rx_enable && tx_state == T_DATA && os_tick && tx_os == `OS_MID;
  wire [7:0] rx_aligned = char_len_sel ? {1'b0, rx_shift_reg[7:1]} : rx_shift_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= R_IDLE;
      rx_os <= 4'h0;
      rx_idx <= 3'd0;
      rx_shift_reg <= 8'h00;
      rx_par <= 1'b0;
      rx_done <= 1'b0;
      rx_frame_bad <= 1'b0;
      rx_par_bad <= 1'b0;
      rx_word <= 8'h00;
    end else begin
      rx_done <= 1'b0;
      if (os_tick) rx_os <= rx_os + 4'h1;
      if (sync_mode) begin
        rx_state <= R_IDLE;
        if (!(tx_state == T_DATA)) rx_idx <= 3'd0;
        if (sync_sample) begin
          rx_shift_reg <= {rxd_s, rx_shift_reg[7:1]};
          rx_idx <= rx_idx + 3'd1;
          if (rx_idx == 3'd7) begin
            rx_word <= {rxd_s, rx_shift_reg[7:1]};
            rx_frame_bad <= 1'b0;
            rx_par_bad <= 1'b0;
            rx_done <= 1'b1;
          end
        end
      end else begin
        case (rx_state)
          R_IDLE: begin
            rx_os <= 4'h0;
            if (rx_enable && !rxd_s) rx_state <= R_START;
          end
          R_START: begin
            if (os_tick && rx_os == `OS_MID) begin
              rx_os <= 4'h0;
              rx_idx <= 3'd0;
              rx_par <= parity_odd;
              rx_state <= rxd_s ? R_IDLE : R_DATA;
            end
          end
          R_DATA: begin
            if (rx_mid) begin
              rx_shift_reg <= {rxd_s, rx_shift_reg[7:1]};
              rx_par <= rx_par ^ rxd_s;
              rx_idx <= rx_idx + 3'd1;
              if (rx_idx == rx_last) rx_state <= parity_enable ? R_PAR : R_STOP;
            end
          end
          R_PAR: begin
            if (rx_mid) begin
              rx_par <= rx_par ^ rxd_s;
              rx_state <= R_STOP;
            end
          end
          R_STOP: begin
            if (rx_mid) begin
              // only the first stop is checked; idle at once so a low starts a frame
              rx_word <= rx_aligned;
              rx_frame_bad <= !rxd_s;
              rx_par_bad <= parity_enable && rx_par;
              rx_done <= 1'b1;
              rx_state <= R_IDLE;
            end
          end
          default: rx_state <= R_IDLE;
        endcase
      end
    end
  end

  // status flags: set wins over clear
  wire rx_clean = rx_done && !rx_frame_bad && !rx_par_bad;
  wire overrun = rx_done && rx_hold_full;
  wire rx_accept = rx_clean && !rx_hold_full;
  wire [4:0] flag_set;
  wire [4:0] flag_hw_clr;
  assign flag_set[`FLAG_PARITY] = rx_done && rx_par_bad;
  assign flag_set[`FLAG_FRAME] = rx_done && rx_frame_bad;
  assign flag_set[`FLAG_OVERRUN] = overrun;
  assign flag_set[`FLAG_RX_FULL] = rx_accept;
  assign flag_set[`FLAG_TX_EMPTY] = !tx_enable || tx_load;
  assign flag_hw_clr[`FLAG_PARITY] = 1'b0;
  assign flag_hw_clr[`FLAG_FRAME] = 1'b0;
  assign flag_hw_clr[`FLAG_OVERRUN] = 1'b0;
  assign flag_hw_clr[`FLAG_RX_FULL] = dma_rx_ack && rx_full_irq;
  assign flag_hw_clr[`FLAG_TX_EMPTY] = dma_tx_we && tx_empty_irq;
  wire stat_wr = wr_lane && hit_stat;

  localparam [4:0] RST_FLAG_VEC = `RST_FLAGS;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_flag
      // a 0 write clears only after that flag was read as 1; a 1 write is ignored
      wire sw_clr = stat_wr && armed[gi] && !pwdata[gi + `STAT_FLAG_LSB];
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flags[gi] <= RST_FLAG_VEC[gi];
          armed[gi] <= 1'b0;
        end else begin
          flags[gi] <= flag_set[gi] || (flags[gi] && !(sw_clr || flag_hw_clr[gi]));
          if (rd_stat) armed[gi] <= prdata[gi + `STAT_FLAG_LSB];
          else if (stat_wr) armed[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  wire tx_hold_empty_clr = (stat_wr && armed[`FLAG_TX_EMPTY] && !pwdata[`FLAG_TX_EMPTY + `STAT_FLAG_LSB])
                  || flag_hw_clr[`FLAG_TX_EMPTY];
  wire tend_set = !tx_enable || (tx_finish && tx_hold_empty);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_end <= `RST_TX_END;
      rx_data <= 8'h00;
      tx_empty_irq <= 1'b0;
      rx_full_irq <= 1'b0;
      rx_err_irq <= 1'b0;
      tx_done_irq <= 1'b0;
    end else begin
      tx_end <= tend_set || (tx_end && !tx_hold_empty_clr);
      if (rx_accept) rx_data <= rx_word;
      tx_empty_irq <= tx_irq_en && tx_hold_empty;
      rx_full_irq <= rx_irq_en && rx_hold_full;
      rx_err_irq <= rx_irq_en && (flags[`FLAG_OVERRUN] || flags[`FLAG_FRAME] || flags[`FLAG_PARITY]);
      tx_done_irq <= txdone_irq_en && tx_end;
    end
  end
endmodule

// ---- src/serial_port_consts.vh ----
// constants for the serial port: register indexes, field positions, resets, timing
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH

// register indexes; byte address on apb is four times the low byte
`define IDX_FRAME_MODE 24'hFFFE90
`define IDX_BIT_RATE_DIVISOR 24'hFFFE91
`define IDX_SERIAL_CONTROL 24'hFFFE92
`define IDX_TX_HOLD 24'hFFFE93
`define IDX_SERIAL_STATUS 24'hFFFE94
`define IDX_RX_HOLD 24'hFFFE95

// frame mode fields
`define MODE_SYNC_BIT 7
`define MODE_CHAR_LEN_BIT 6
`define MODE_PARITY_EN_BIT 5
`define MODE_PARITY_ODD_BIT 4
`define MODE_STOP_LEN_BIT 3
`define MODE_PRESCALE_HI 1
`define MODE_PRESCALE_LO 0

// control fields
`define CTL_TX_IRQ_EN_BIT 7
`define CTL_RX_IRQ_EN_BIT 6
`define CTL_TX_EN_BIT 5
`define CTL_RX_EN_BIT 4
`define CTL_TXDONE_IRQ_EN_BIT 2
`define CTL_CLK_SRC_HI 1
`define CTL_CLK_SRC_LO 0

// status fields; flag vector index i sits at bit i+3
`define STAT_FLAG_LSB 3
`define STAT_TX_END_BIT 2
`define FLAG_PARITY 0
`define FLAG_FRAME 1
`define FLAG_OVERRUN 2
`define FLAG_RX_FULL 3
`define FLAG_TX_EMPTY 4

// reset values
`define RST_FRAME_MODE 8'h00
`define RST_DIVISOR 8'hFF
`define RST_CONTROL 8'h00
`define RST_FLAGS 5'h10
`define RST_TX_END 1'b1

// timing in oversample ticks
`define OS_LAST 4'hF
`define OS_MID 4'h7
`define CLK_SRC_INTERNAL 2'h0

`endif

// ---- src/baud_tick_gen.v ----
// bit rate generator: prescaler then divisor, one-cycle 16x oversample tick
`timescale 1ns/1ps
module baud_tick_gen (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire [1:0] prescale,
  input wire [7:0] divisor,
  output reg tick
);
  reg [6:0] pre_cnt;
  reg [7:0] div_cnt;
  reg [6:0] pre_max;

  // prescale divides by 2, 8, 32 or 128: 16x tick = pclk / (2 * 4^n * (divisor + 1))
  always @* begin
    case (prescale)
      2'h0: pre_max = 7'h01;
      2'h1: pre_max = 7'h07;
      2'h2: pre_max = 7'h1F;
      default: pre_max = 7'h7F;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 7'h00;
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (!run) begin
        pre_cnt <= 7'h00;
        div_cnt <= 8'h00;
      end else if (pre_cnt >= pre_max) begin
        pre_cnt <= 7'h00;
        if (div_cnt >= divisor) begin
          div_cnt <= 8'h00;
          tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 8'h01;
        end
      end else begin
        pre_cnt <= pre_cnt + 7'h01;
      end
    end
  end
endmodule

// ---- verification/serial_port_async_sync_assertions.sv ----
// checker on the serial port ports: apb answer, irq gating, line idle levels
`timescale 1ns/1ps
module serial_port_async_sync_assertions (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire dma_rx_ack,
  input wire txd,
  input wire sck,
  input wire tx_empty_irq,
  input wire rx_full_irq,
  input wire rx_err_irq,
  input wire tx_done_irq
);
  logic [7:0] ctl_q;
  logic [7:0] mode_q;
  wire acc = psel && penable && pready;
  wire wr_ok = acc && pwrite && pstrb[0];
  wire st_rd = acc && !pwrite && paddr[9:2] == 8'h94;
  // shadows move on the same edge as the registers they mirror
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 8'h00;
      mode_q <= 8'h00;
    end else if (wr_ok && paddr[9:2] == 8'h92) begin
      ctl_q <= pwdata[7:0];
    end else if (wr_ok && paddr[9:2] == 8'h90) begin
      mode_q <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_err: assert property (acc && (paddr[9:2] < 8'h90 || paddr[9:2] > 8'h95)
    |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  a_empty_when_off: assert property (st_rd && !ctl_q[5] && !$past(ctl_q[5], 3)
    |-> prdata[7]) else $error("tx empty low while tx disabled");
  a_txirq_gated: assert property (tx_empty_irq |-> $past(ctl_q[7]))
    else $error("tx empty request without enable");
  a_rxirq_gated: assert property (rx_full_irq || rx_err_irq |-> $past(ctl_q[6]))
    else $error("rx request without enable");
  a_done_gated: assert property (tx_done_irq |-> $past(ctl_q[2]))
    else $error("tx done request without enable");
  a_start_needs_en: assert property ($fell(txd) |-> ctl_q[5])
    else $error("txd moved while tx disabled");
  a_sck_async_idle: assert property (!mode_q[7] |-> sck)
    else $error("sck moved in async mode");
  a_ack_clears_full: assert property (dma_rx_ack && rx_full_irq
    |-> ##[1:3] !rx_full_irq) else $error("dma read left rx full set");
  c_write: cover property (wr_ok);
  c_start: cover property ($fell(txd));
  c_rx_err: cover property (rx_err_irq);
  c_ack: cover property (dma_rx_ack && rx_full_irq);
endmodule

bind serial_port_async_sync serial_port_async_sync_assertions i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .dma_rx_ack(dma_rx_ack), .txd(txd), .sck(sck),
  .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq), .rx_err_irq(rx_err_irq),
  .tx_done_irq(tx_done_irq)
);

// ---- verification/serial_peer.sv ----
// remote serial peer: drives frames on rxd, samples txd frames at bit centre
`timescale 1ns/1ps
module serial_peer (
  input wire pclk,
  input wire txd,
  output logic rxd
);
  int bit_cyc = 32;
  logic [11:0] got;
  logic lost;
  initial rxd = 1'b1;
  // last > 0 shortens the final bit, so a low stop does not look like a new start
  task automatic send(input logic [15:0] v, input int n, input int last = 0);
    for (int i = 0; i < n; i++) begin
      rxd <= v[i];
      repeat ((i == n - 1 && last > 0) ? last : bit_cyc) @(posedge pclk);
    end
    // back to idle high, one cycle gap before any next start
    rxd <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic capture(input int n);
    int k;
    got = 12'h0;
    lost = 1'b1;
    for (k = 0; k < 4000 && txd; k++) @(posedge pclk);
    if (!txd) begin
      lost = 1'b0;
      repeat (bit_cyc / 2) @(posedge pclk);
      for (k = 0; k < n; k++) begin
        repeat (bit_cyc) @(posedge pclk);
        got[k] = txd;
      end
    end
  endtask
endmodule

// ---- verification/serial_port_async_sync_tb.sv ----
// self-checking bench: registers, frames both ways, status flags, dma, irq gating
`timescale 1ns/1ps
module serial_port_async_sync_tb;
  localparam logic [31:0] A_MODE = 32'h240;
  localparam logic [31:0] A_DIV = 32'h244;
  localparam logic [31:0] A_CTL = 32'h248;
  localparam logic [31:0] A_TXH = 32'h24C;
  localparam logic [31:0] A_ST = 32'h250;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [31:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0] pstrb = 4'hF;
  logic dma_tx_we = 0;
  logic dma_rx_ack = 0;
  logic [7:0] dma_tx_data = 0;
  wire [31:0] prdata;
  wire [7:0] rx_data;
  wire pready, pslverr, rxd, txd, sck;
  wire tx_empty_irq, rx_full_irq, rx_err_irq, tx_done_irq;
  int error_cnt = 0;
  int num_checks = 0;
  int k;
  logic [31:0] rd;
  logic err;
  logic [15:0] f;
  logic [7:0] d, d0, m;
  logic [7:0] modes [5] = '{8'h00, 8'h40, 8'h30, 8'h08, 8'h68};
  always #2 pclk = ~pclk;
  serial_port_async_sync i_serial_port_async_sync (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_tx_we(dma_tx_we), .dma_tx_data(dma_tx_data), .dma_rx_ack(dma_rx_ack),
    .rx_data(rx_data), .rxd(rxd), .txd(txd), .sck(sck), .tx_empty_irq(tx_empty_irq),
    .rx_full_irq(rx_full_irq), .rx_err_irq(rx_err_irq), .tx_done_irq(tx_done_irq));
  serial_peer i_serial_peer (.pclk(pclk), .txd(txd), .rxd(rxd));
  task automatic give_verdict;
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // expected bits after the start bit, count in the top nibble
  function automatic logic [15:0] frame(input logic [7:0] md, input logic [7:0] v);
    logic [11:0] b;
    int n;
    b = 12'h0;
    n = md[6] ? 7 : 8;
    b[7:0] = md[6] ? {1'b0, v[6:0]} : v;
    if (md[5]) begin
      b[n] = ^b[7:0] ^ md[4];
      n++;
    end
    b[n] = 1'b1;
    b[n + 1] = md[3];
    return {4'(n + 1 + md[3]), b};
  endfunction
  task automatic tx_sw(input logic [7:0] v);
    f = frame(m, v);
    fork
      i_serial_peer.capture(f[15:12]);
      begin
        apb(A_TXH, 1, {24'h0, v});
        apb(A_ST, 0, 0);
        apb(A_ST, 1, 32'h7F);
      end
    join
    chk("tx start", 0, i_serial_peer.lost);
    chk("tx frame", f[11:0], i_serial_peer.got);
  endtask
  task automatic rx_send(input logic [7:0] v, input int flip, input int last = 0);
    logic [15:0] vec;
    f = frame(m, v);
    vec = {3'h0, f[11:0], 1'b0};
    if (flip >= 0) vec[flip] = ~vec[flip];
    i_serial_peer.send(vec, f[15:12] + 1, last);
    repeat (4) @(posedge pclk);
  endtask
  task automatic clr;
    apb(A_ST, 0, 0);
    apb(A_ST, 1, 32'h80);
  endtask
  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hAF0B));
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(A_ST, 0, 0);
    chk("status reset", 32'h84, rd);
    apb(A_DIV, 0, 0);
    chk("divisor reset", 32'hFF, rd);
    apb(32'h2FC, 0, 0);
    chk("unmapped err", 1, err);
    apb(A_DIV, 1, 0);
    apb(A_CTL, 1, 32'hF4);
    repeat (2) @(posedge pclk);
    chk("tx empty irq", 1, tx_empty_irq);
    foreach (modes[i]) begin
      m = modes[i];
      apb(A_MODE, 1, m);
      tx_sw($urandom);
      d = $urandom;
      rx_send(d, -1);
      chk("rx data", frame(m, d) & 16'h00FF & (m[6] ? 16'h7F : 16'hFF), rx_data);
      apb(A_ST, 0, 0);
      chk("rx flags", 4'b1000, rd[6:3]);
      clr();
    end
    for (k = 0; k < 2; k++) begin
      i_serial_peer.bit_cyc = k ? 128 : 64;
      apb(A_DIV, 1, k ? 0 : 1);
      m = k ? 8'h01 : 8'h00;
      apb(A_MODE, 1, m);
      tx_sw($urandom);
    end
    i_serial_peer.bit_cyc = 32;
    apb(A_DIV, 1, 0);
    m = 8'h08;
    apb(A_MODE, 1, m);
    d0 = $urandom;
    rx_send(d0, -1);
    rx_send($urandom, -1);
    apb(A_ST, 0, 0);
    chk("overrun", 2'b11, rd[6:5]);
    chk("kept data", d0, rx_data);
    apb(A_CTL, 1, 32'hE4);
    apb(A_ST, 0, 0);
    chk("full after rx off", 1, rd[6]);
    apb(A_CTL, 1, 32'hF4);
    apb(A_ST, 1, 32'hFF);
    apb(A_ST, 0, 0);
    chk("ones write", 2'b11, rd[6:5]);
    apb(A_ST, 1, 32'h80);
    apb(A_ST, 0, 0);
    chk("cleared", 4'b0000, rd[6:3]);
    m = 8'h00;
    apb(A_MODE, 1, m);
    rx_send($urandom, 9, 20);
    apb(A_ST, 0, 0);
    chk("frame err", 4'b0010, rd[6:3]);
    chk("err irq", 1, rx_err_irq);
    chk("data after err", d0, rx_data);
    clr();
    apb(A_ST, 0, 0);
    chk("frame err clr", 0, rd[4]);
    m = 8'h20;
    apb(A_MODE, 1, m);
    rx_send($urandom, 9);
    apb(A_ST, 0, 0);
    chk("parity err", 4'b0001, rd[6:3]);
    clr();
    m = 8'h00;
    apb(A_MODE, 1, m);
    rx_send($urandom, -1);
    chk("full irq", 1, rx_full_irq);
    @(posedge pclk);
    dma_rx_ack <= 1;
    @(posedge pclk);
    dma_rx_ack <= 0;
    apb(A_ST, 0, 0);
    chk("dma read", 0, rd[6]);
    d = $urandom;
    f = frame(m, d);
    fork
      i_serial_peer.capture(f[15:12]);
      begin
        @(posedge pclk);
        dma_tx_we <= 1;
        dma_tx_data <= d;
        @(posedge pclk);
        dma_tx_we <= 0;
      end
    join
    chk("dma frame", f[11:0], i_serial_peer.got);
    repeat (400) @(posedge pclk);
    chk("tx done irq", 1, tx_done_irq);
    apb(A_CTL, 1, 32'h30);
    repeat (2) @(posedge pclk);
    chk("irqs off", 2'b00, {tx_empty_irq, tx_done_irq});
    rx_send($urandom, -1);
    chk("rx irq off", 0, rx_full_irq);
    clr();
    apb(A_CTL, 1, 32'h10);
    apb(A_TXH, 1, 32'h55);
    apb(A_ST, 0, 0);
    apb(A_ST, 1, 32'h7F);
    apb(A_ST, 0, 0);
    chk("empty while off", 1, rd[7]);
    err = 0;
    for (k = 0; k < 200; k++) begin
      @(posedge pclk);
      if (txd !== 1'b1) err = 1;
    end
    chk("txd idle off", 0, err);
    apb(A_MODE, 1, 32'h80);
    apb(A_CTL, 1, 32'h30);
    apb(A_TXH, 1, 32'hA5);
    apb(A_ST, 0, 0);
    apb(A_ST, 1, 32'h7F);
    d = 0;
    err = sck;
    for (k = 0; k < 600; k++) begin
      @(posedge pclk);
      if (sck === 1'b0 && err === 1'b1) d++;
      err = sck;
    end
    chk("sync clocks", 8, d);
    give_verdict();
  end
endmodule
